// *** hdl/pfr_pkg.sv ***
// constants for the closed-loop frequency regulator
package pfr_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int DIV_STEPS = 40;
  localparam logic [15:0] REMOTE_FB_ADDR = 16'h001e;
  localparam logic [15:0] REMOTE_FB_RESET = 16'h0000;
  localparam logic [15:0] PCT_FULL = 16'h03e8;
  localparam logic [4:0] FUNC_LOOP_BYPASS = 5'h15;
  localparam logic [3:0] FREQ_SRC_UPDOWN = 4'ha;
  localparam logic [15:0] TI_TICKS_PER_UNIT = 16'h000a;
  localparam logic [15:0] TD_TICKS_PER_UNIT = 16'h000a;
  localparam logic [15:0] SLEEP_TICKS_PER_UNIT = 16'h0064;
  localparam logic ENABLE_DEF = 1'h0;
  localparam logic UNIT_DEF = 1'h0;
  localparam logic MODE_DEF = 1'h0;
  localparam logic [2:0] REF_SRC_DEF = 3'h0;
  localparam logic [1:0] FB_SRC_DEF = 2'h2;
  localparam logic [13:0] KP_DEF = 14'h0bb8;
  localparam logic [11:0] TI_DEF = 12'h064;
  localparam logic [11:0] TD_DEF = 12'h000;
  localparam logic [15:0] HI_DEF = 16'h1770;
  localparam logic [15:0] LO_DEF = 16'h0032;
  localparam logic [15:0] MAXF_DEF = 16'h1770;
  localparam logic [15:0] SLEEP_DLY_DEF = 16'h0258;
  localparam logic [15:0] SLEEP_F_DEF = 16'h0000;
  localparam logic [9:0] WAKE_DEF = 10'h15e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DIV = 3'b010,
    ST_UPD = 3'b100
  } pfr_state_e;
endpackage : pfr_pkg

// *** hdl/pfr_regulator.sv ***
// closed-loop frequency regulator with bypass and sleep supervision
`timescale 1ns/1ps
module pfr_regulator #(
  parameter int TICK_CYCLES = pfr_pkg::TICK_CYCLES,
  parameter int NUM_INPUTS = 5
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic settings_load_in,
  input wire logic loop_enable_select_in,
  input wire logic loop_unit_select_in,
  input wire logic loop_mode_select_in,
  input wire logic [2:0] reference_source_select_in,
  input wire logic [1:0] feedback_source_select_in,
  input wire logic [13:0] proportional_gain_in,
  input wire logic [11:0] integral_time_in,
  input wire logic [11:0] derivative_time_in,
  input wire logic [15:0] output_upper_limit_in,
  input wire logic [15:0] output_lower_limit_in,
  input wire logic [15:0] maximum_frequency_in,
  input wire logic [15:0] sleep_delay_time_in,
  input wire logic [15:0] sleep_frequency_in,
  input wire logic [9:0] wake_up_level_in,
  input wire logic [5*NUM_INPUTS-1:0] input_terminal_function_in,
  input wire logic [NUM_INPUTS-1:0] multi_function_inputs_in,
  input wire logic [15:0] keypad_ref1_in,
  input wire logic [15:0] keypad_ref2_in,
  input wire logic [15:0] remote_reference_in,
  input wire logic [9:0] main_voltage_input_in,
  input wire logic [9:0] auxiliary_analog_current_in,
  input wire logic [9:0] auxiliary_analog_voltage_in,
  input wire logic [15:0] main_frequency_reference_in,
  input wire logic [3:0] main_frequency_source_in,
  input wire logic run_cmd_in,
  input wire logic stop_cmd_in,
  input wire logic [15:0] rs485_addr_in,
  input wire logic rs485_wr_in,
  input wire logic [15:0] rs485_wdata_in,
  output logic [15:0] rs485_rdata_out,
  output logic [15:0] operating_frequency_out,
  output logic motor_run_out,
  output logic sleep_active_out,
  output logic loop_bypass_out,
  output logic [15:0] loop_feedback_value_out,
  output logic [15:0] loop_reference_value_out,
  output logic [15:0] monitor_value_out,
  output logic [15:0] normal_loop_output_out,
  output logic signed [16:0] loop_correction_output_out
);

  // percent in 0.1% steps to 0.01 Hz, full scale at maximum frequency
  function automatic logic [15:0] pct_to_hz(input logic [15:0] p, input logic [15:0] maxf);
    logic [31:0] prod;
    prod = p * maxf;
    return 16'(prod / 32'(pfr_pkg::PCT_FULL));
  endfunction : pct_to_hz

  // settings shadow, loaded as one set so limits stay consistent
  logic en_q, unit_q, mode_q;
  logic [2:0] ref_src_q;
  logic [1:0] fb_src_q;
  logic [13:0] kp_q;
  logic [11:0] ti_q, td_q;
  logic [15:0] hi_q, lo_q, maxf_q, sleep_dly_q, sleep_f_q;
  logic [9:0] wake_q;
  // a load with upper below lower is dropped whole, not half taken
  wire load_ok = settings_load_in && (output_upper_limit_in >= output_lower_limit_in);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      en_q <= pfr_pkg::ENABLE_DEF;
      unit_q <= pfr_pkg::UNIT_DEF;
      mode_q <= pfr_pkg::MODE_DEF;
      ref_src_q <= pfr_pkg::REF_SRC_DEF;
      fb_src_q <= pfr_pkg::FB_SRC_DEF;
      kp_q <= pfr_pkg::KP_DEF;
      ti_q <= pfr_pkg::TI_DEF;
      td_q <= pfr_pkg::TD_DEF;
      hi_q <= pfr_pkg::HI_DEF;
      lo_q <= pfr_pkg::LO_DEF;
      maxf_q <= pfr_pkg::MAXF_DEF;
      sleep_dly_q <= pfr_pkg::SLEEP_DLY_DEF;
      sleep_f_q <= pfr_pkg::SLEEP_F_DEF;
      wake_q <= pfr_pkg::WAKE_DEF;
    end else if (load_ok) begin
      en_q <= loop_enable_select_in;
      unit_q <= loop_unit_select_in;
      mode_q <= loop_mode_select_in;
      ref_src_q <= reference_source_select_in;
      fb_src_q <= feedback_source_select_in;
      kp_q <= proportional_gain_in;
      ti_q <= (integral_time_in == 12'h000) ? 12'h001 : integral_time_in;
      td_q <= derivative_time_in;
      hi_q <= output_upper_limit_in;
      lo_q <= output_lower_limit_in;
      maxf_q <= maximum_frequency_in;
      sleep_dly_q <= sleep_delay_time_in;
      sleep_f_q <= sleep_frequency_in;
      wake_q <= wake_up_level_in;
    end
  end

  // terminal pins pass two flops before anything reads them
  logic [NUM_INPUTS-1:0] mfi_meta_q, mfi_sync_q, bypass_hit;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_term
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          mfi_meta_q[gi] <= 1'b0;
          mfi_sync_q[gi] <= 1'b0;
        end else begin
          mfi_meta_q[gi] <= multi_function_inputs_in[gi];
          mfi_sync_q[gi] <= mfi_meta_q[gi];
        end
      end
      assign bypass_hit[gi] = mfi_sync_q[gi] &&
        (input_terminal_function_in[5*gi +: 5] == pfr_pkg::FUNC_LOOP_BYPASS);
    end
  endgenerate
  wire bypass = |bypass_hit;

  // remote feedback word, always in 0.1% whatever the unit
  logic [15:0] remote_fb_q, rdata_q;
  wire remote_hit = (rs485_addr_in == pfr_pkg::REMOTE_FB_ADDR);
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      remote_fb_q <= pfr_pkg::REMOTE_FB_RESET;
      rdata_q <= 16'h0000;
    end else begin
      if (rs485_wr_in && remote_hit)
        remote_fb_q <= rs485_wdata_in;
      rdata_q <= remote_hit ? remote_fb_q : 16'h0000;
    end
  end

  // source selection; analog inputs arrive as 0.1% of full scale
  wire [15:0] mv_pct = {6'h00, main_voltage_input_in};
  wire [15:0] ai_pct = {6'h00, auxiliary_analog_current_in};
  wire [15:0] av_pct = {6'h00, auxiliary_analog_voltage_in};
  wire [15:0] fb_pct = (fb_src_q == 2'h0) ? ai_pct :
                       (fb_src_q == 2'h1) ? av_pct :
                       (fb_src_q == 2'h2) ? mv_pct : remote_fb_q;
  wire [15:0] fb_hz = pct_to_hz(fb_pct, maxf_q);
  wire [15:0] fb_unit = unit_q ? fb_pct : fb_hz;
  wire [15:0] mv_unit = unit_q ? mv_pct : pct_to_hz(mv_pct, maxf_q);
  wire [15:0] ai_unit = unit_q ? ai_pct : pct_to_hz(ai_pct, maxf_q);
  wire [15:0] av_unit = unit_q ? av_pct : pct_to_hz(av_pct, maxf_q);
  wire [15:0] ref_unit = (ref_src_q == 3'h0) ? keypad_ref1_in :
                         (ref_src_q == 3'h1) ? keypad_ref2_in :
                         (ref_src_q == 3'h2) ? mv_unit :
                         (ref_src_q == 3'h3) ? ai_unit :
                         (ref_src_q == 3'h4) ? av_unit :
                         (ref_src_q == 3'h5) ? remote_reference_in : 16'h0000;
  wire [15:0] ref_hz = unit_q ? pct_to_hz(ref_unit, maxf_q) : ref_unit;
  wire [15:0] main_hz = (main_frequency_source_in == pfr_pkg::FREQ_SRC_UPDOWN) ?
                        16'h0000 : main_frequency_reference_in;

  wire signed [17:0] err = $signed({2'b00, ref_hz}) - $signed({2'b00, fb_hz});

  // 1 ms sample enable
  logic [15:0] tick_cnt_q;
  wire tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || tick)
      tick_cnt_q <= 16'h0000;
    else
      tick_cnt_q <= tick_cnt_q + 16'h0001;
  end

  logic run_q, sleep_q;
  wire loop_live = en_q && !bypass && !sleep_q && run_q;

  // integral: error sum over ticks divided by integral time in ticks
  wire [15:0] ti_ticks = 16'(ti_q * pfr_pkg::TI_TICKS_PER_UNIT);
  wire [15:0] td_ticks = 16'(td_q * pfr_pkg::TD_TICKS_PER_UNIT);
  // product taken at full width, a 16-bit one would wrap the windup bound
  wire [31:0] sum_lim_mag = {16'h0000, hi_q} * {16'h0000, ti_ticks};
  wire signed [39:0] sum_lim = $signed({8'h00, sum_lim_mag});
  logic signed [39:0] sum_q;
  wire signed [39:0] sum_raw = sum_q + 40'(err);
  // anti-windup: integral alone never asks for more than the upper limit
  wire signed [39:0] sum_nx = (sum_raw > sum_lim) ? sum_lim :
                              (sum_raw < -sum_lim) ? -sum_lim : sum_raw;
  wire [39:0] sum_mag = sum_nx[39] ? 40'(-sum_nx) : 40'(sum_nx);

  pfr_pkg::pfr_state_e state_q;
  logic signed [17:0] err_q, err_prev_q;
  logic signed [18:0] derr_q;
  logic [39:0] quo_q;
  logic [16:0] rem_q;
  logic [5:0] div_cnt_q;
  logic neg_q;
  logic signed [41:0] u_q;
  wire [16:0] rem_sh = {rem_q[15:0], quo_q[39]};
  wire div_fit = (rem_sh >= {1'b0, ti_ticks});

  wire signed [32:0] p_prod = err_q * $signed({1'b0, kp_q});
  wire signed [32:0] p_term = p_prod / 33'sd1000;
  wire signed [35:0] d_term = derr_q * $signed({1'b0, td_ticks});
  wire signed [41:0] i_term = neg_q ? -$signed({2'b00, quo_q}) : $signed({2'b00, quo_q});
  wire signed [41:0] u_nx = 42'(p_term) + i_term + 42'(d_term);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= pfr_pkg::ST_IDLE;
      sum_q <= 40'sh0;
      err_q <= 18'sh0;
      err_prev_q <= 18'sh0;
      derr_q <= 19'sh0;
      quo_q <= 40'h0;
      rem_q <= 17'h0;
      div_cnt_q <= 6'h0;
      neg_q <= 1'b0;
      u_q <= 42'sh0;
    end else begin
      case (state_q)
        pfr_pkg::ST_IDLE: begin
          if (!loop_live) begin
            sum_q <= 40'sh0;
            err_prev_q <= 18'sh0;
            u_q <= 42'sh0;
          end else if (tick) begin
            err_q <= err;
            derr_q <= 19'(err) - 19'(err_prev_q);
            err_prev_q <= err;
            sum_q <= sum_nx;
            quo_q <= sum_mag;
            neg_q <= sum_nx[39];
            rem_q <= 17'h0;
            div_cnt_q <= 6'h0;
            state_q <= pfr_pkg::ST_DIV;
          end
        end
        pfr_pkg::ST_DIV: begin
          rem_q <= div_fit ? 17'(rem_sh - {1'b0, ti_ticks}) : rem_sh;
          quo_q <= {quo_q[38:0], div_fit};
          div_cnt_q <= div_cnt_q + 6'h1;
          if (div_cnt_q == 6'(pfr_pkg::DIV_STEPS - 1))
            state_q <= pfr_pkg::ST_UPD;
        end
        pfr_pkg::ST_UPD: begin
          // a loop that went idle mid-divide must not leave a stale term
          if (loop_live)
            u_q <= u_nx;
          else
            u_q <= 42'sh0;
          state_q <= pfr_pkg::ST_IDLE;
        end
        default: state_q <= pfr_pkg::ST_IDLE;
      endcase
    end
  end

  // output shaping
  wire signed [41:0] hi_s = $signed({26'h0, hi_q});
  wire signed [41:0] lo_s = $signed({26'h0, lo_q});
  wire signed [41:0] maxf_s = $signed({26'h0, maxf_q});
  wire [15:0] norm_out = (u_q < lo_s) ? lo_q :
                         (u_q > hi_s) ? hi_q : u_q[15:0];
  wire signed [41:0] corr = (u_q > hi_s) ? hi_s :
                            (u_q < -hi_s) ? -hi_s : u_q;
  wire signed [41:0] psum = $signed({26'h0, main_hz}) + corr;
  wire [15:0] proc_out = (psum > maxf_s) ? maxf_q :
                         (psum < lo_s) ? lo_q : psum[15:0];
  wire [15:0] ctrl_out = mode_q ? proc_out : norm_out;
  wire [15:0] bypass_hz = mode_q ? main_hz : ref_hz;
  wire [15:0] op_nx = !en_q ? main_hz :
                      bypass ? bypass_hz :
                      (sleep_q || !run_q) ? 16'h0000 : ctrl_out;

  // sleep supervision
  logic [23:0] sleep_cnt_q;
  // long delays need more than 16 bits of ticks
  wire [23:0] sleep_ticks = {8'h00, sleep_dly_q} * {8'h00, pfr_pkg::SLEEP_TICKS_PER_UNIT};
  wire [17:0] err_mag = err[17] ? 18'(-err) : 18'(err);
  wire [15:0] wake_hz = pct_to_hz({6'h00, wake_q}, maxf_q);
  wire wake = (err_mag > {2'b00, wake_hz});
  wire at_sleep_f = (ctrl_out == sleep_f_q);
  wire sleep_due = en_q && run_q && !bypass && at_sleep_f && (sleep_cnt_q >= sleep_ticks);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      run_q <= 1'b0;
      sleep_q <= 1'b0;
      sleep_cnt_q <= 24'h0;
    end else begin
      // stop wins over run so a late wake cannot restart
      if (stop_cmd_in)
        run_q <= 1'b0;
      else if (run_cmd_in)
        run_q <= 1'b1;
      if (stop_cmd_in || !en_q || bypass)
        sleep_q <= 1'b0;
      else if (sleep_q && wake)
        sleep_q <= 1'b0;
      else if (sleep_due)
        sleep_q <= 1'b1;
      if (!loop_live || !at_sleep_f)
        sleep_cnt_q <= 24'h0;
      else if (tick && sleep_cnt_q != 24'hffffff)
        sleep_cnt_q <= sleep_cnt_q + 24'h1;
    end
  end

  // monitor and data outputs
  logic [15:0] op_q, fb_mon_q, ref_mon_q, mon_q, norm_q;
  logic signed [16:0] corr_q;
  logic bypass_q;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      op_q <= 16'h0000;
      fb_mon_q <= 16'h0000;
      ref_mon_q <= 16'h0000;
      mon_q <= 16'h0000;
      norm_q <= 16'h0000;
      corr_q <= 17'sh0;
      bypass_q <= 1'b0;
    end else begin
      op_q <= op_nx;
      fb_mon_q <= fb_unit;
      ref_mon_q <= ref_unit;
      mon_q <= bypass ? op_nx : fb_unit;
      norm_q <= norm_out;
      corr_q <= corr[16:0];
      bypass_q <= bypass;
    end
  end

  assign rs485_rdata_out = rdata_q;
  assign operating_frequency_out = op_q;
  assign motor_run_out = run_q && !sleep_q;
  assign sleep_active_out = sleep_q;
  assign loop_bypass_out = bypass_q;
  assign loop_feedback_value_out = fb_mon_q;
  assign loop_reference_value_out = ref_mon_q;
  assign monitor_value_out = mon_q;
  assign normal_loop_output_out = norm_q;
  assign loop_correction_output_out = corr_q;

endmodule : pfr_regulator

// *** testbench/pfr_regulator_chk.sv ***
// port checker for the frequency regulator
`timescale 1ns/1ps
module pfr_regulator_chk #(
  parameter int TICK_CYCLES = pfr_pkg::TICK_CYCLES,
  parameter int NUM_INPUTS = 5
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic settings_load_in,
  input wire logic loop_enable_select_in,
  input wire logic loop_mode_select_in,
  input wire logic [15:0] output_upper_limit_in,
  input wire logic [15:0] output_lower_limit_in,
  input wire logic [15:0] maximum_frequency_in,
  input wire logic [NUM_INPUTS-1:0] multi_function_inputs_in,
  input wire logic stop_cmd_in,
  input wire logic [15:0] rs485_addr_in,
  input wire logic rs485_wr_in,
  input wire logic [15:0] rs485_wdata_in,
  input wire logic [15:0] rs485_rdata_out,
  input wire logic [15:0] operating_frequency_out,
  input wire logic motor_run_out,
  input wire logic sleep_active_out,
  input wire logic loop_bypass_out,
  input wire logic [15:0] monitor_value_out,
  input wire logic [15:0] normal_loop_output_out,
  input wire logic signed [16:0] loop_correction_output_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [15:0] hi_q, max_q;
  logic en_q, mode_q;
  int unsigned age_q;
  wire settled = age_q > TICK_CYCLES + 64;
  wire load_ok = settings_load_in && output_upper_limit_in >= output_lower_limit_in;
  wire fb_addr = rs485_addr_in == pfr_pkg::REMOTE_FB_ADDR;
  // own shadow of the limits; a refused load must leave them alone
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hi_q <= pfr_pkg::HI_DEF;
      max_q <= pfr_pkg::MAXF_DEF;
      en_q <= pfr_pkg::ENABLE_DEF;
      mode_q <= pfr_pkg::MODE_DEF;
    end else if (load_ok) begin
      hi_q <= output_upper_limit_in;
      max_q <= maximum_frequency_in;
      en_q <= loop_enable_select_in;
      mode_q <= loop_mode_select_in;
    end
  end
  // bounds only hold once a full tick has passed since new limits
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || load_ok) age_q <= 0;
    else if (!settled) age_q <= age_q + 1;
  end
  a_rd_unmapped: assert property (!fb_addr |=> rs485_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_rd_written: assert property (rs485_wr_in && fb_addr ##1 fb_addr && !rs485_wr_in |=>
    rs485_rdata_out == $past(rs485_wdata_in, 2)) else $error("remote feedback readback wrong");
  a_bypass_idle: assert property ((!(|multi_function_inputs_in)) [*4] |-> !loop_bypass_out)
    else $error("bypass without any terminal");
  a_bypass_monitor: assert property (loop_bypass_out [*3] ##0 $stable(operating_frequency_out)
    |-> monitor_value_out == operating_frequency_out) else $error("monitor not on frequency");
  a_stop_cancel: assert property (stop_cmd_in |=> !motor_run_out && !sleep_active_out)
    else $error("stop did not cancel run or sleep");
  a_sleep_halt: assert property (sleep_active_out |-> !motor_run_out)
    else $error("motor runs while asleep");
  a_sleep_zero: assert property (sleep_active_out && en_q |=>
    loop_bypass_out || operating_frequency_out == 16'h0000) else $error("frequency not zero while asleep");
  a_normal_bound: assert property (settled |-> normal_loop_output_out <= hi_q)
    else $error("normal output above upper limit");
  a_corr_limit: assert property (settled |-> loop_correction_output_out <= $signed({1'b0, hi_q})
    && loop_correction_output_out >= -$signed({1'b0, hi_q})) else $error("correction out of limit");
  a_sum_bound: assert property ((settled && en_q && mode_q && !loop_bypass_out) [*4]
    |-> operating_frequency_out <= max_q) else $error("process sum above maximum");
endmodule : pfr_regulator_chk
bind pfr_regulator pfr_regulator_chk #(.TICK_CYCLES(TICK_CYCLES), .NUM_INPUTS(NUM_INPUTS)) pfr_regulator_chk_i (.*);

// *** testbench/pfr_far_side.sv ***
// analog sensors and remote master beside the regulator
`timescale 1ns/1ps
module pfr_far_side (
  input wire logic clk_in,
  input wire logic [15:0] rs485_rdata_in,
  output logic [9:0] main_voltage_out,
  output logic [9:0] aux_current_out,
  output logic [9:0] aux_voltage_out,
  output logic [15:0] rs485_addr_out,
  output logic rs485_wr_out,
  output logic [15:0] rs485_wdata_out
);
  initial begin
    main_voltage_out = 10'h000;
    aux_current_out = 10'h000;
    aux_voltage_out = 10'h000;
    rs485_addr_out = 16'h0000;
    rs485_wr_out = 1'b0;
    rs485_wdata_out = 16'h0000;
  end
  task automatic set_analog(input logic [9:0] mv, input logic [9:0] ac, input logic [9:0] av);
    main_voltage_out <= mv;
    aux_current_out <= ac;
    aux_voltage_out <= av;
  endtask : set_analog
  // released lines show the inverse so a stale value never passes
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge clk_in);
    rs485_addr_out <= addr;
    rs485_wr_out <= wr;
    rs485_wdata_out <= wd;
    @(posedge clk_in);
    rs485_wr_out <= 1'b0;
    @(posedge clk_in);
    @(negedge clk_in);
    rd = rs485_rdata_in;
    @(posedge clk_in);
    rs485_addr_out <= ~addr;
    rs485_wdata_out <= ~wd;
  endtask : access
endmodule : pfr_far_side

// *** testbench/pfr_regulator_bench.sv ***
// self-checking bench for the frequency regulator
`timescale 1ns/1ps
module pfr_regulator_bench;
  localparam int TICK = 100;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, settings_load_in = 1'b0, run_cmd_in = 1'b0, stop_cmd_in = 1'b0;
  logic loop_enable_select_in = 1'b1, loop_unit_select_in = 1'b1, loop_mode_select_in = 1'b0;
  logic [2:0] reference_source_select_in = 3'h0;
  logic [1:0] feedback_source_select_in = 2'h2;
  logic [13:0] proportional_gain_in = pfr_pkg::KP_DEF;
  logic [11:0] integral_time_in = pfr_pkg::TI_DEF, derivative_time_in = 12'h000;
  logic [15:0] output_upper_limit_in = 16'h0fa0, output_lower_limit_in = pfr_pkg::LO_DEF;
  logic [15:0] maximum_frequency_in = pfr_pkg::MAXF_DEF, sleep_delay_time_in = 16'h0001;
  logic [15:0] sleep_frequency_in = pfr_pkg::LO_DEF, main_frequency_reference_in = 16'h0bb8;
  logic [9:0] wake_up_level_in = pfr_pkg::WAKE_DEF;
  logic [24:0] input_terminal_function_in = 25'h0005400;
  logic [4:0] multi_function_inputs_in = 5'h00;
  logic [15:0] keypad_ref1_in = 16'h0065, keypad_ref2_in = 16'h00ca, remote_reference_in = 16'h025e;
  logic [3:0] main_frequency_source_in = 4'h0;
  logic [9:0] main_voltage_input_in, auxiliary_analog_current_in, auxiliary_analog_voltage_in;
  logic [15:0] rs485_addr_in, rs485_wdata_in, rs485_rdata_out, operating_frequency_out, rd;
  logic rs485_wr_in, motor_run_out, sleep_active_out, loop_bypass_out;
  logic [15:0] loop_feedback_value_out, loop_reference_value_out, monitor_value_out, normal_loop_output_out;
  logic signed [16:0] loop_correction_output_out;
  int errors = 0, n_tests = 0;
  int rows[6][4] = '{'{0, 0, 101, 404}, '{1, 1, 202, 505}, '{2, 2, 303, 303}, '{3, 3, 404, 707},
    '{4, 0, 505, 404}, '{5, 1, 606, 505}};
  int clp[4][4] = '{'{0, 1000, 4000, 4000}, '{0, 0, 50, 50}, '{1, 1000, 6000, 4000}, '{1, 0, 50, -4000}};
  logic [15:0] byp[3] = '{16'h0065, 16'h025e, 16'h0bb8};
  pfr_regulator #(.TICK_CYCLES(TICK)) pfr_regulator_i (.*);
  pfr_far_side pfr_far_side_i (.clk_in(clk_in), .rs485_rdata_in(rs485_rdata_out),
    .main_voltage_out(main_voltage_input_in), .aux_current_out(auxiliary_analog_current_in),
    .aux_voltage_out(auxiliary_analog_voltage_in), .rs485_addr_out(rs485_addr_in),
    .rs485_wr_out(rs485_wr_in), .rs485_wdata_out(rs485_wdata_in));
  always #12.5 clk_in = ~clk_in;
  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic done(input string what);
    $display("test %s finished, mismatches so far %0d", what, errors);
  endtask : done
  task automatic load();
    settings_load_in <= 1'b1;
    @(posedge clk_in);
    settings_load_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : load
  // w picks motor run (1) or sleep (0); a spent bound ends the run
  task automatic waitv(input bit w, input logic v, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(negedge clk_in);
      if ((w ? motor_run_out : sleep_active_out) === v) break;
    end
    if (k == lim) begin
      errors++;
      $display("Error at %0t: wait ran out", $time);
      results();
    end
    @(posedge clk_in);
  endtask : waitv
  initial begin
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    chk(operating_frequency_out, 16'h0000, "frequency in reset");
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    pfr_far_side_i.set_analog(10'h12f, 10'h194, 10'h1f9);
    pfr_far_side_i.access(1'b0, 16'h001e, 16'h0000, rd);
    chk(rd, 16'h0000, "remote feedback after reset");
    pfr_far_side_i.access(1'b1, 16'h001e, 16'h02c3, rd);
    pfr_far_side_i.access(1'b1, 16'h001f, 16'h1234, rd);
    pfr_far_side_i.access(1'b0, 16'h001f, 16'h0000, rd);
    chk(rd, 16'h0000, "unmapped read");
    pfr_far_side_i.access(1'b0, 16'h001e, 16'h0000, rd);
    chk(rd, 16'h02c3, "remote feedback readback");
    done("remote register");
    foreach (rows[i]) begin
      reference_source_select_in <= 3'(rows[i][0]);
      feedback_source_select_in <= 2'(rows[i][1]);
      load();
      @(negedge clk_in);
      chk(loop_reference_value_out, 16'(rows[i][2]), "reference source");
      chk(loop_feedback_value_out, 16'(rows[i][3]), "feedback source");
      @(posedge clk_in);
    end
    done("sources");
    loop_unit_select_in <= 1'b0;
    reference_source_select_in <= 3'h0;
    feedback_source_select_in <= 2'h2;
    load();
    @(negedge clk_in);
    chk(loop_reference_value_out, 16'h0065, "hertz reference");
    chk(loop_feedback_value_out, 16'h071a, "hertz feedback");
    @(posedge clk_in);
    run_cmd_in <= 1'b1;
    multi_function_inputs_in <= 5'h04;
    for (int j = 0; j < 3; j++) begin
      loop_unit_select_in <= 1'(j > 0);
      loop_mode_select_in <= 1'(j > 1);
      load();
      repeat (4) @(posedge clk_in);
      @(negedge clk_in);
      chk(operating_frequency_out, byp[j], "bypass frequency");
      chk(monitor_value_out, byp[j], "bypass monitor");
      chk(loop_bypass_out, 1'b1, "bypass flag");
      @(posedge clk_in);
    end
    main_frequency_source_in <= pfr_pkg::FREQ_SRC_UPDOWN;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk(operating_frequency_out, 16'h0000, "up-down main reference");
    @(posedge clk_in);
    main_frequency_source_in <= 4'h0;
    multi_function_inputs_in <= 5'h00;
    loop_enable_select_in <= 1'b0;
    load();
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    chk(operating_frequency_out, 16'h0bb8, "loop switched off");
    @(posedge clk_in);
    done("bypass");
    loop_enable_select_in <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      loop_mode_select_in <= 1'(clp[j][0]);
      keypad_ref1_in <= 16'(clp[j][1]);
      pfr_far_side_i.set_analog(10'(1000 - clp[j][1]), 10'h194, 10'h1f9);
      load();
      repeat (3 * TICK) @(posedge clk_in);
      @(negedge clk_in);
      chk(operating_frequency_out, 16'(clp[j][2]), "clamped frequency");
      chk(clp[j][0] ? loop_correction_output_out : 17'(normal_loop_output_out), 17'(clp[j][3]), "term");
      @(posedge clk_in);
    end
    done("limits");
    // stopping first empties the integrator before the sleep runs
    run_cmd_in <= 1'b0;
    stop_cmd_in <= 1'b1;
    loop_mode_select_in <= 1'b0;
    keypad_ref1_in <= 16'h01f4;
    pfr_far_side_i.set_analog(10'h1f4, 10'h194, 10'h1f9);
    load();
    stop_cmd_in <= 1'b0;
    run_cmd_in <= 1'b1;
    waitv(1'b0, 1'b1, 120 * TICK);
    @(negedge clk_in);
    chk(motor_run_out, 1'b0, "motor while asleep");
    @(posedge clk_in);
    run_cmd_in <= 1'b0;
    stop_cmd_in <= 1'b1;
    @(posedge clk_in);
    stop_cmd_in <= 1'b0;
    pfr_far_side_i.set_analog(10'h000, 10'h194, 10'h1f9);
    repeat (5 * TICK) @(posedge clk_in);
    @(negedge clk_in);
    chk(sleep_active_out, 1'b0, "sleep after stop");
    chk(motor_run_out, 1'b0, "restart after stop");
    @(posedge clk_in);
    pfr_far_side_i.set_analog(10'h1f4, 10'h194, 10'h1f9);
    run_cmd_in <= 1'b1;
    waitv(1'b0, 1'b1, 120 * TICK);
    pfr_far_side_i.set_analog(10'h000, 10'h194, 10'h1f9);
    waitv(1'b0, 1'b0, 5 * TICK);
    @(negedge clk_in);
    chk(motor_run_out, 1'b1, "wake on deviation");
    done("sleep");
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk(operating_frequency_out, 16'h0000, "frequency in second reset");
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    pfr_far_side_i.access(1'b0, 16'h001e, 16'h0000, rd);
    chk(rd, 16'h0000, "remote feedback after second reset");
    done("reset");
    results();
  end
endmodule : pfr_regulator_bench
